// ### design/ssp_map.svh
// constants of the serial host port: widths, depths, bit positions
`ifndef SSP_MAP_SVH
`define SSP_MAP_SVH
`define SSP_WORD_W     8
`define SSP_FIFO_DEPTH 32
`define SSP_MSB        7
`define SSP_CNT_W      3
`define SSP_BIT_FIRST  3'h0
`define SSP_BIT_LAST   3'h7
`define SSP_CNT_STEP   3'h1
`endif

// ### design/ssp_pkg.sv
// types shared by the serial host port files
`include "ssp_map.svh"
package ssp_pkg;
  typedef struct packed {
    logic                     vld;
    logic [`SSP_WORD_W-1:0]   data;
  } ssp_byte_t;

  typedef enum logic [1:0] {
    SSP_IDLE,
    SSP_SEL_WAIT,
    SSP_XFER
  } ssp_state_t;

  typedef struct packed {
    logic                     cs_s1;
    logic                     cs_s2;
    logic                     rxt_s1;
    logic                     rxt_s2;
    logic                     rxt_d;
    logic                     ack_s1;
    logic                     ack_s2;
    logic                     ack_d;
    ssp_state_t               state;
    logic                     irq_n;
    logic                     tx_full;
    logic [`SSP_WORD_W-1:0]   tx_word;
    ssp_byte_t                rx;
  } ssp_core_t;

  typedef struct packed {
    logic [`SSP_CNT_W-1:0]    cnt;
    logic [`SSP_WORD_W-1:0]   sh;
  } ssp_shift_t;

  typedef struct packed {
    logic                     tgl;
    logic [`SSP_WORD_W-1:0]   hold;
  } ssp_rxhand_t;

  typedef struct packed {
    logic                     tgl;
    logic                     dout;
  } ssp_txhand_t;
endpackage

// ### design/ssp_fifo.sv
// outbound byte fifo with registered read data
`timescale 1ns/100ps
`include "ssp_map.svh"
module ssp_fifo #(
  parameter int W = `SSP_WORD_W,
  parameter int D = `SSP_FIFO_DEPTH
) (
  // system
  input  wire logic           clk_i,
  input  wire logic           nrst_i,
  // fill side
  input  wire logic           in_vld_i,
  input  wire logic [W-1:0]   in_data_i,
  output logic                in_ready_o,
  // drain side
  output logic                out_vld_o,
  output logic [W-1:0]        out_data_o,
  input  wire logic           out_ready_i
);
  import ssp_pkg::*;
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0]      mem;
    logic [AW:0]              wp;
    logic [AW:0]              rp;
    logic                     vld;
    logic [W-1:0]             dout;
  } ssp_fifo_st_t;

  ssp_fifo_st_t st;
  ssp_fifo_st_t next_st;
  logic         full;
  logic         empty;

  always_comb begin
    full    = (st.wp[AW] != st.rp[AW]) && (st.wp[AW-1:0] == st.rp[AW-1:0]);
    empty   = (st.wp == st.rp);
    next_st = st;
    if (in_vld_i && !full) begin
      next_st.mem[st.wp[AW-1:0]] = in_data_i;
      next_st.wp = st.wp + 1'b1;
    end
    // output register refills as soon as it is free or being taken
    if (!empty && (!st.vld || out_ready_i)) begin
      next_st.dout = st.mem[st.rp[AW-1:0]];
      next_st.rp   = st.rp + 1'b1;
      next_st.vld  = 1'b1;
    end else if (out_ready_i) begin
      next_st.vld = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign in_ready_o = !full;
  assign out_vld_o  = st.vld;
  assign out_data_o = st.dout;
endmodule

// ### design/ssp_host_port.sv
// serial slave host port: link shifters, crossings, select/irq handshake
`timescale 1ns/100ps
`include "ssp_map.svh"
// Overview of operation
// - The host is master driving clock, select and inbound data; this port drives outbound data and irq.
// - A falling select is taken as the host asking for a transfer and starts the handshake.
// - All port-to-host bits leave on the outbound data line, driven by this port alone.
// - With the link idle, irq follows the waiting outbound byte one clock late: low a clock after it is held, high a clock after it leaves.
// - Irq driven low after select means the port is ready to accept host data.
// - After select falls the port holds irq high until its core is ready, then pulls it low.
// - Select is treated as asynchronous and passes two flip-flops before the control logic acts.
// - Data launch and capture use opposite clock edges, launch on rising by default, selectable.
module ssp_host_port (
  // system
  input  wire logic                clk_i,
  input  wire logic                nrst_i,
  // serial link
  input  wire logic                sclk_i,
  input  wire logic                cs_n_i,
  input  wire logic                din_i,
  output logic                     dout_o,
  output logic                     irq_n_o,
  // configuration and core status
  input  wire logic                cfg_capture_rise_i,
  input  wire logic                core_ready_i,
  // outbound byte stream
  input  wire ssp_pkg::ssp_byte_t  tx_i,
  output logic                     tx_ready_o,
  // inbound byte stream
  output ssp_pkg::ssp_byte_t       rx_o
);
  import ssp_pkg::*;

  ssp_core_t               st;
  ssp_core_t               next_st;
  ssp_shift_t              cap;
  ssp_shift_t              next_cap;
  ssp_shift_t              lau;
  ssp_shift_t              next_lau;
  ssp_rxhand_t             rxh;
  ssp_rxhand_t             next_rxh;
  ssp_txhand_t             txh;
  ssp_txhand_t             next_txh;
  logic                    cap_clk;
  logic                    lrst_n;
  logic                    ack_ev;
  logic                    fifo_vld;
  logic [`SSP_WORD_W-1:0]  fifo_data;
  logic                    fifo_pop;
  logic                    tx_msb;

  // outbound buffer; the user stalls on tx_ready_o when it fills
  ssp_fifo #(
    .W (`SSP_WORD_W),
    .D (`SSP_FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .nrst_i      (nrst_i),
    .in_vld_i    (tx_i.vld),
    .in_data_i   (tx_i.data),
    .in_ready_o  (tx_ready_o),
    .out_vld_o   (fifo_vld),
    .out_data_o  (fifo_data),
    .out_ready_i (fifo_pop)
  );

  // ---------------- link domain ----------------
  // static edge choice; change only while deselected
  assign cap_clk = sclk_i ^ ~cfg_capture_rise_i;
  // bit counters end with the frame, the clock may stop outside it
  assign lrst_n  = nrst_i & ~cs_n_i;
  assign tx_msb  = st.tx_word[`SSP_MSB];

  always_comb begin
    next_cap     = cap;
    next_rxh     = rxh;
    next_cap.cnt = cap.cnt + `SSP_CNT_STEP;
    next_cap.sh  = {cap.sh[`SSP_MSB-1:0], din_i};
    if (cap.cnt == `SSP_BIT_LAST) begin
      next_rxh.hold = {cap.sh[`SSP_MSB-1:0], din_i};
      next_rxh.tgl  = ~rxh.tgl;
    end
  end

  always_ff @(posedge cap_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      cap <= '0;
    end else begin
      cap <= next_cap;
    end
  end

  // toggle survives the frame end so no false event appears
  always_ff @(posedge cap_clk or negedge nrst_i) begin
    if (!nrst_i) begin
      rxh <= '0;
    end else begin
      rxh <= next_rxh;
    end
  end

  always_comb begin
    next_lau     = lau;
    next_txh     = txh;
    next_lau.cnt = lau.cnt + `SSP_CNT_STEP;
    if (lau.cnt == `SSP_BIT_FIRST) begin
      // word is stable: core reloads it only after seeing this toggle
      next_lau.sh  = {st.tx_word[`SSP_MSB-1:0], 1'b0};
      next_txh.dout = tx_msb;
      next_txh.tgl = ~txh.tgl;
    end else begin
      next_lau.sh  = {lau.sh[`SSP_MSB-1:0], 1'b0};
      next_txh.dout = lau.sh[`SSP_MSB];
    end
  end

  always_ff @(negedge cap_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      lau <= '0;
    end else begin
      lau <= next_lau;
    end
  end

  always_ff @(negedge cap_clk or negedge nrst_i) begin
    if (!nrst_i) begin
      txh <= '0;
    end else begin
      txh <= next_txh;
    end
  end

  assign dout_o = txh.dout;

  // ---------------- core domain ----------------
  always_comb begin
    next_st        = st;
    next_st.cs_s1  = cs_n_i;
    next_st.cs_s2  = st.cs_s1;
    next_st.rxt_s1 = rxh.tgl;
    next_st.rxt_s2 = st.rxt_s1;
    next_st.rxt_d  = st.rxt_s2;
    next_st.ack_s1 = txh.tgl;
    next_st.ack_s2 = st.ack_s1;
    next_st.ack_d  = st.ack_s2;
    ack_ev         = (st.ack_s2 != st.ack_d);
    fifo_pop       = 1'b0;
    next_st.rx.vld = 1'b0;
    if (st.rxt_s2 != st.rxt_d) begin
      next_st.rx.vld  = 1'b1;
      next_st.rx.data = rxh.hold;
    end
    // an empty buffer sends zeros rather than repeating a stale byte
    if (ack_ev) begin
      next_st.tx_full = 1'b0;
      next_st.tx_word = '0;
    end
    if (fifo_vld && (ack_ev || (st.state == SSP_IDLE && !st.tx_full))) begin
      fifo_pop        = 1'b1;
      next_st.tx_full = 1'b1;
      next_st.tx_word = fifo_data;
    end
    unique case (st.state)
      SSP_IDLE: begin
        next_st.irq_n = !st.tx_full;
        if (!st.cs_s2) begin
          next_st.state = SSP_SEL_WAIT;
          next_st.irq_n = 1'b1;
        end
      end
      SSP_SEL_WAIT: begin
        next_st.irq_n = 1'b1;
        if (st.cs_s2) begin
          next_st.state = SSP_IDLE;
        end else if (core_ready_i) begin
          next_st.state = SSP_XFER;
          next_st.irq_n = 1'b0;
        end
      end
      SSP_XFER: begin
        // launch edges only arrive from here on, the host waits for irq
        next_st.irq_n = 1'b0;
        if (st.cs_s2) begin
          next_st.state = SSP_IDLE;
          next_st.irq_n = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st       <= '0;
      st.cs_s1 <= 1'b1;
      st.cs_s2 <= 1'b1;
      st.irq_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign irq_n_o = st.irq_n;
  assign rx_o    = st.rx;

  // ---------------- checks ----------------
  a_sel_starts: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (st.state == SSP_IDLE && !st.cs_s2) |=> (st.state == SSP_SEL_WAIT && st.irq_n))
    else $error("select did not start the handshake");
  a_cs_synced: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (st.state == SSP_IDLE && st.cs_s2) |=> (st.state == SSP_IDLE))
    else $error("idle left without synchronised select");
  a_idle_irq_data: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (st.state == SSP_IDLE && st.cs_s2 && st.tx_full) |=> !irq_n_o)
    else $error("pending byte not flagged on irq");
  a_idle_irq_quiet: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (st.state == SSP_IDLE && !st.tx_full) |=> irq_n_o)
    else $error("irq low in idle without data");
  a_ready_irq_low: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (st.state == SSP_SEL_WAIT && !st.cs_s2 && core_ready_i)
      |=> (!irq_n_o && st.state == SSP_XFER) [*2])
    else $error("ready not signalled on irq");
  a_wait_irq_high: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (st.state == SSP_IDLE && !st.cs_s2) |=> irq_n_o ##1 (irq_n_o || $past(core_ready_i)))
    else $error("irq low before core ready");
  a_tx_reload: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (ack_ev && fifo_vld) |=> (st.tx_full && st.tx_word == $past(fifo_data)))
    else $error("outbound word not reloaded after launch");
  a_rx_single: assert property (@(posedge clk_i) disable iff (!nrst_i)
    rx_o.vld |=> !rx_o.vld [*3])
    else $error("inbound byte strobe too long");
  a_launch_msb: assert property (@(negedge cap_clk) disable iff (!lrst_n)
    (lau.cnt == `SSP_BIT_FIRST) |=> (dout_o == $past(tx_msb)))
    else $error("first launched bit is not the word msb");
  a_capture_byte: assert property (@(posedge cap_clk) disable iff (!lrst_n)
    (cap.cnt == `SSP_BIT_LAST) |=> (rxh.hold[0] == $past(din_i) && rxh.tgl != $past(rxh.tgl)))
    else $error("inbound byte not closed on eighth capture");

  c_read_frame: cover property (@(posedge clk_i) disable iff (!nrst_i)
    (st.state == SSP_IDLE && !irq_n_o) ##[1:20] (st.state == SSP_XFER));
  c_write_frame: cover property (@(posedge clk_i) disable iff (!nrst_i)
    (st.state == SSP_SEL_WAIT) ##[1:200] rx_o.vld);
  c_fifo_full: cover property (@(posedge clk_i) disable iff (!nrst_i) !tx_ready_o);
endmodule

// ### tb/ssp_host_model.sv
// host-side master model that drives the serial link of the host port
`timescale 1ns/100ps
module ssp_host_model (
  // link
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      din_o,
  input  wire logic dout_i,
  input  wire logic irq_n_i,
  // mode
  input  wire logic cap_rise_i
);
  localparam int HALF = 24;
  logic [7:0] sent_q[$];
  logic [7:0] got_q[$];
  int         wait_err = 0;

  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o = 1'b0;
  end

  task automatic frame(input int nb);
    logic [7:0] t;
    logic [7:0] r;
    int         n;
    // clock stands at idle level outside frames
    sclk_o = cap_rise_i;
    #HALF;
    cs_n_o = 1'b0;
    #60;
    n = 0;
    // no clock edge until irq answers low
    while (irq_n_i !== 1'b0 && n < 500) begin
      #10;
      n++;
    end
    if (n >= 500) wait_err++;
    repeat (nb) begin
      t = 8'($urandom);
      for (int i = 7; i >= 0; i--) begin
        sclk_o = ~sclk_o;
        din_o = t[i];
        #HALF;
        sclk_o = ~sclk_o;
        r[i] = dout_i;
        #HALF;
      end
      sent_q.push_back(t);
      got_q.push_back(r);
      // pause between bytes: clock rate may drop toward zero
      #($urandom_range(60));
    end
    cs_n_o = 1'b1;
    // released line must not show stale data
    din_o = ~din_o;
  endtask
endmodule

// ### tb/tb_top.sv
// self-checking bench for the serial host port
`timescale 1ns/100ps
module tb_top;
  import ssp_pkg::*;
  logic       clk_i = 1'b0;
  logic       nrst_i = 1'b0;
  logic       cfg = 1'b0;
  logic       core_ready = 1'b0;
  ssp_byte_t  tx = '0;
  ssp_byte_t  rx;
  logic       sclk, cs_n, din, dout, irq_n, tx_ready, ok;
  logic [7:0] exp_q[$];
  logic [7:0] rx_q[$];
  int         errors = 0;
  int         check_count = 0;
  int         acc;

  always #5 clk_i = ~clk_i;

  ssp_host_port DUT (.clk_i(clk_i), .nrst_i(nrst_i), .sclk_i(sclk), .cs_n_i(cs_n),
    .din_i(din), .dout_o(dout), .irq_n_o(irq_n), .cfg_capture_rise_i(cfg),
    .core_ready_i(core_ready), .tx_i(tx), .tx_ready_o(tx_ready), .rx_o(rx));
  ssp_host_model HOST (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .dout_i(dout),
    .irq_n_i(irq_n), .cap_rise_i(cfg));

  // sampled mid-cycle, where the one-cycle strobe has settled
  always @(negedge clk_i) if (rx.vld === 1'b1) rx_q.push_back(rx.data);

  task automatic chk(input string n, input logic [8:0] e, input logic [8:0] s);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  // next outbound byte the host should see: push order, zero once none is queued
  function automatic logic [8:0] exp_tx();
    logic [8:0] v;
    v = 9'h0;
    if (exp_q.size() > 0) v = {1'b0, exp_q.pop_front()};
    return v;
  endfunction

  // oldest captured inbound byte, all ones when nothing arrived
  function automatic logic [8:0] seen_rx();
    logic [8:0] v;
    v = 9'h1ff;
    if (rx_q.size() > 0) v = {1'b0, rx_q.pop_front()};
    return v;
  endfunction

  task automatic end_of_test;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic do_reset(input logic mode);
    @(negedge clk_i);
    nrst_i = 1'b0;
    cfg = mode;
    repeat (20) @(negedge clk_i);
    chk("rst_irq", 9'h1, {8'h0, irq_n});
    chk("rst_ready", 9'h1, {8'h0, tx_ready});
    chk("rst_rx", 9'h0, rx);
    // reset empties the outbound path, so nothing is owed any more
    exp_q.delete();
    nrst_i = 1'b1;
    repeat (3) @(negedge clk_i);
  endtask

  task automatic push(input logic [7:0] b, output logic k);
    @(negedge clk_i);
    tx = {1'b1, b};
    k = tx_ready;
    if (k) exp_q.push_back(b);
  endtask

  task automatic ready_seq;
    int d;
    d = 6 + $urandom_range(14);
    @(negedge cs_n);
    repeat (d) @(negedge clk_i);
    chk("irq_wait", 9'h1, {8'h0, irq_n});
    core_ready = 1'b1;
    repeat (3) @(negedge clk_i);
    chk("irq_ready", 9'h0, {8'h0, irq_n});
    @(posedge cs_n);
    @(negedge clk_i);
    core_ready = 1'b0;
  endtask

  task automatic xfer(input int nb);
    fork
      HOST.frame(nb);
      ready_seq();
    join
    repeat (10) @(negedge clk_i);
    while (HOST.got_q.size() > 0)
      chk("dout", exp_tx(), {1'b0, HOST.got_q.pop_front()});
    while (HOST.sent_q.size() > 0)
      chk("rx", {1'b0, HOST.sent_q.pop_front()}, seen_rx());
    chk("rx_extra", 9'h0, 9'(rx_q.size()));
  endtask

  initial begin
    #400000;
    errors++;
    end_of_test();
  end

  initial begin
    void'($urandom(45));
    do_reset(1'b0);
    chk("irq_empty", 9'h1, {8'h0, irq_n});
    xfer(2);
    for (int k = 0; k < 6; k++) begin
      repeat (1 + $urandom_range(3)) push(8'($urandom), ok);
      @(negedge clk_i);
      tx.vld = 1'b0;
      repeat (6) @(negedge clk_i);
      chk("irq_pending", 9'h0, {8'h0, irq_n});
      xfer(1 + $urandom_range(3));
    end
    // fill with the link stalled until the buffer refuses
    acc = 0;
    ok = 1'b1;
    while (ok && acc < 40) begin
      push(8'($urandom), ok);
      if (ok) acc++;
    end
    @(negedge clk_i);
    tx.vld = 1'b0;
    chk("refused", 9'h0, {8'h0, tx_ready});
    // 32 buffered words, the output register and the holding word
    chk("fill", 9'h22, 9'(exp_q.size()));
    chk("irq_full", 9'h0, {8'h0, irq_n});
    for (int k = 0; k < 30 && exp_q.size() > 0; k++) xfer(1 + $urandom_range(4));
    repeat (6) @(negedge clk_i);
    chk("irq_drained", 9'h1, {8'h0, irq_n});
    // swapped edge arrangement
    do_reset(1'b1);
    repeat (2) push(8'($urandom), ok);
    @(negedge clk_i);
    tx.vld = 1'b0;
    xfer(3);
    chk("wait_err", 9'h0, HOST.wait_err[8:0]);
    end_of_test();
  end
endmodule
